// file: pkg/spp_pkg.sv
// Package with register map, field layout, reset values and types of the port.
package spp_pkg;

  // Register byte offsets on the register bus.
  localparam logic [7:0] OFF_PORT = 8'h00;
  localparam logic [7:0] OFF_DIR = 8'h04;
  localparam logic [7:0] OFF_CFG = 8'h08;
  localparam logic [7:0] OFF_INTCTL = 8'h0C;
  localparam logic [7:0] OFF_STAT = 8'h10;
  localparam logic [7:0] OFF_MASK = 8'h14;

  // Field positions inside the configuration and interrupt registers.
  localparam int CFG_OSC_LSB = 0;
  localparam int CFG_RST_PIN_BIT = 3;
  localparam int CFG_CLK_OUT_BIT = 4;
  localparam int CFG_PULLUP_BIT = 5;
  localparam int CFG_ANA_LSB = 8;
  localparam int INTCTL_IE_BIT = 3;
  localparam int STAT_CHG_BIT = 0;

  // Values after reset.
  localparam logic [5:0] DIR_RST = 6'h3F;
  localparam logic [7:0] LATCH_RST = 8'h00;
  localparam logic [3:0] ANA_RST = 4'hF;
  localparam logic [2:0] SNAP_RST = 3'h0;

  // Bus response codes.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Oscillator modes; the unlisted codes behave as crystal modes.
  typedef enum logic [2:0] {
    OSC_LP = 3'h0,
    OSC_XT = 3'h1,
    OSC_HS = 3'h2,
    OSC_INT_RC = 3'h4,
    OSC_EXT_RC = 3'h6
  } spp_osc_t;

  localparam logic [2:0] OSC_RST = 3'h4;

  // Decoded register selection.
  typedef enum logic [2:0] {
    REG_PORT = 3'h0,
    REG_DIR = 3'h1,
    REG_CFG = 3'h2,
    REG_INTCTL = 3'h3,
    REG_STAT = 3'h4,
    REG_MASK = 3'h5,
    REG_NONE = 3'h7
  } spp_reg_t;

  // Whole state of the port block.
  typedef struct packed {
    logic [5:0] pinMeta;
    logic [5:0] pinSync;
    logic sdaMeta;
    logic sdaSync;
    logic [7:0] latch;
    logic [5:0] dir;
    logic [2:0] oscMode;
    logic rstPinEn;
    logic clkOutEn;
    logic pullupEn;
    logic [3:0] anaSel;
    logic portChangeIntEnable;
    logic [2:0] snap;
    logic chgFlag;
    logic chgMask;
    logic awHave;
    logic [7:0] awAddr;
    logic wHave;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    spp_reg_t rdIdx;
  } spp_state_t;

endpackage

// file: src/spp_port.sv
// Six-pin general-purpose port with direction control and change interrupt.
//
// Our own choices: the AXI4-Lite slave port and the placing of the registers.
module spp_port
  import spp_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter bit HAS_EEPROM = 1'b1
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic [5:0] gpIn,
  output logic [5:0] gpOut,
  output logic [5:0] gpOe,
  output logic [5:0] pullUpOn,
  input wire logic clkOutSig,
  input wire logic eeSdaIn,
  output logic eeSdaOut,
  output logic eeSclOut,
  output logic irq
);

  // Maps a byte address onto a register; unaligned or unknown is none.
  function automatic spp_reg_t regIndex(input logic [ADDR_W-1:0] addr);
    logic [7:0] a;
    a = 8'(addr);
    unique case (a)
      OFF_PORT: regIndex = REG_PORT;
      OFF_DIR: regIndex = REG_DIR;
      OFF_CFG: regIndex = REG_CFG;
      OFF_INTCTL: regIndex = REG_INTCTL;
      OFF_STAT: regIndex = REG_STAT;
      OFF_MASK: regIndex = REG_MASK;
      default: regIndex = REG_NONE;
    endcase
  endfunction

  // Merges written bytes into an old word under the byte strobes.
  function automatic logic [31:0] mergeBytes(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        m[8*b+:8] = nw[8*b+:8];
      end
    end
    return m;
  endfunction

  // Only the two RC modes leave pins four and five to the port.
  function automatic logic isRcMode(input logic [2:0] m);
    return (m == OSC_INT_RC) || (m == OSC_EXT_RC);
  endfunction

  localparam spp_state_t ST_RST = '{
    pinMeta: 6'h00, pinSync: 6'h00, sdaMeta: 1'b0, sdaSync: 1'b0,
    latch: LATCH_RST, dir: DIR_RST, oscMode: OSC_RST, rstPinEn: 1'b0,
    clkOutEn: 1'b0, pullupEn: 1'b0, anaSel: ANA_RST,
    portChangeIntEnable: 1'b0, snap: SNAP_RST, chgFlag: 1'b0,
    chgMask: 1'b0, awHave: 1'b0, awAddr: 8'h00, wHave: 1'b0,
    wData: 32'h0000_0000, wStrb: 4'h0, bvalid: 1'b0, bresp: RESP_OKAY,
    rvalid: 1'b0, rresp: RESP_OKAY, rdata: 32'h0000_0000,
    rdIdx: REG_NONE
  };

  spp_state_t s_q;
  spp_state_t s_d;
  logic rcMode;
  logic extOsc;
  logic clkOutOn;
  logic [5:0] altMask;
  logic [5:0] dirEff;
  logic [7:0] portView;
  logic [7:0] dirView;
  logic [31:0] cfgView;
  logic [31:0] intctlView;
  logic [31:0] statView;
  logic [31:0] maskView;
  logic wrDo;
  spp_reg_t wIdx;
  spp_reg_t arIdx;
  logic [31:0] rdValue;
  logic [31:0] wMerged;
  logic [2:0] chgPins;
  logic [2:0] chgEnable;
  logic chgNow;

  // Oscillator and alternate-function decode shared by reads and drivers.
  always_comb begin
    rcMode = isRcMode(s_q.oscMode);
    extOsc = !rcMode;
    clkOutOn = s_q.clkOutEn && rcMode;
    altMask[0] = s_q.anaSel[0];
    altMask[1] = s_q.anaSel[1];
    altMask[2] = s_q.anaSel[2];
    altMask[3] = s_q.rstPinEn;
    altMask[4] = s_q.anaSel[3] || extOsc || clkOutOn;
    altMask[5] = extOsc;
  end

  // Effective direction: pin three always input, four and five forced to input outside the RC modes.
  always_comb begin
    dirEff[2:0] = s_q.dir[2:0];
    dirEff[3] = 1'b1;
    dirEff[5:4] = rcMode ? s_q.dir[5:4] : 2'b11;
  end

  // Register views as software reads them.
  always_comb begin
    portView[5:0] = s_q.pinSync & ~altMask;
    portView[6] = HAS_EEPROM ? s_q.sdaSync : 1'b0;
    portView[7] = HAS_EEPROM ? s_q.latch[7] : 1'b0;
    dirView = {2'b00, dirEff};
    cfgView = 32'h0000_0000;
    cfgView[CFG_OSC_LSB+:3] = s_q.oscMode;
    cfgView[CFG_RST_PIN_BIT] = s_q.rstPinEn;
    cfgView[CFG_CLK_OUT_BIT] = s_q.clkOutEn;
    cfgView[CFG_PULLUP_BIT] = s_q.pullupEn;
    cfgView[CFG_ANA_LSB+:4] = s_q.anaSel;
    intctlView = 32'h0000_0000;
    intctlView[INTCTL_IE_BIT] = s_q.portChangeIntEnable;
    statView = 32'h0000_0000;
    statView[STAT_CHG_BIT] = s_q.chgFlag;
    maskView = 32'h0000_0000;
    maskView[STAT_CHG_BIT] = s_q.chgMask;
  end

  // Read multiplexer for the address being accepted.
  always_comb begin
    arIdx = regIndex(araddr);
    unique case (arIdx)
      REG_PORT: rdValue = {24'h00_0000, portView};
      REG_DIR: rdValue = {24'h00_0000, dirView};
      REG_CFG: rdValue = cfgView;
      REG_INTCTL: rdValue = intctlView;
      REG_STAT: rdValue = statView;
      REG_MASK: rdValue = maskView;
      default: rdValue = 32'h0000_0000;
    endcase
  end

  // A write is carried out once both address and data are held.
  always_comb begin
    wrDo = s_q.awHave && s_q.wHave && !s_q.bvalid;
    wIdx = regIndex(ADDR_W'(s_q.awAddr));
    unique case (wIdx)
      REG_PORT: wMerged = mergeBytes({24'h00_0000, s_q.latch},
                                     s_q.wData, s_q.wStrb);
      REG_DIR: wMerged = mergeBytes({26'h000_0000, s_q.dir},
                                    s_q.wData, s_q.wStrb);
      REG_CFG: wMerged = mergeBytes(cfgView, s_q.wData, s_q.wStrb);
      REG_INTCTL: wMerged = mergeBytes(intctlView, s_q.wData, s_q.wStrb);
      REG_STAT: wMerged = s_q.wData & {{8{s_q.wStrb[3]}},
                                       {8{s_q.wStrb[2]}},
                                       {8{s_q.wStrb[1]}},
                                       {8{s_q.wStrb[0]}}};
      REG_MASK: wMerged = mergeBytes(maskView, s_q.wData, s_q.wStrb);
      default: wMerged = 32'h0000_0000;
    endcase
  end

  // Change detection on pins 0, 1 and 3 against the last read snapshot.
  always_comb begin
    chgPins = {s_q.pinSync[3], s_q.pinSync[1], s_q.pinSync[0]};
    chgEnable = {!s_q.rstPinEn, 1'b1, 1'b1};
    chgNow = s_q.portChangeIntEnable
             && |((chgPins ^ s_q.snap) & chgEnable);
  end

  // Next-state logic of the whole block.
  always_comb begin
    s_d = s_q;
    s_d.pinMeta = gpIn;
    s_d.pinSync = s_q.pinMeta;
    s_d.sdaMeta = eeSdaIn;
    s_d.sdaSync = s_q.sdaMeta;
    if (awvalid && awready) begin
      s_d.awHave = 1'b1;
      s_d.awAddr = 8'(awaddr);
    end
    if (wvalid && wready) begin
      s_d.wHave = 1'b1;
      s_d.wData = wdata;
      s_d.wStrb = wstrb;
    end
    if (s_q.bvalid && bready) begin
      s_d.bvalid = 1'b0;
    end
    if (wrDo) begin
      s_d.awHave = 1'b0;
      s_d.wHave = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = (wIdx == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
      unique case (wIdx)
        REG_PORT: s_d.latch = wMerged[7:0];
        REG_DIR: begin
          s_d.dir[2:0] = wMerged[2:0];
          s_d.dir[3] = 1'b1;
          if (rcMode) begin
            s_d.dir[5:4] = wMerged[5:4];
          end
        end
        REG_CFG: begin
          s_d.oscMode = wMerged[CFG_OSC_LSB+:3];
          s_d.rstPinEn = wMerged[CFG_RST_PIN_BIT];
          s_d.clkOutEn = wMerged[CFG_CLK_OUT_BIT];
          s_d.pullupEn = wMerged[CFG_PULLUP_BIT];
          s_d.anaSel = wMerged[CFG_ANA_LSB+:4];
        end
        REG_INTCTL: s_d.portChangeIntEnable = wMerged[INTCTL_IE_BIT];
        REG_STAT: begin
          if (wMerged[STAT_CHG_BIT]) begin
            s_d.chgFlag = 1'b0;
          end
        end
        REG_MASK: s_d.chgMask = wMerged[STAT_CHG_BIT];
        default: s_d.bresp = RESP_SLVERR;
      endcase
    end
    if (s_q.rvalid && rready) begin
      s_d.rvalid = 1'b0;
    end
    if (arvalid && arready) begin
      s_d.rvalid = 1'b1;
      s_d.rdata = rdValue;
      s_d.rdIdx = arIdx;
      s_d.rresp = (arIdx == REG_NONE) ? RESP_SLVERR : RESP_OKAY;
      if (arIdx == REG_PORT) begin
        s_d.snap = chgPins;
      end
    end
    // Hardware set wins over a software clear in the same cycle.
    if (chgNow) begin
      s_d.chgFlag = 1'b1;
    end
  end

  // State register; reset puts every pin back to an input.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= ST_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Bus handshake outputs.
  assign awready = !s_q.awHave && !s_q.bvalid;
  assign wready = !s_q.wHave && !s_q.bvalid;
  assign arready = !s_q.rvalid;
  assign bvalid = s_q.bvalid;
  assign bresp = s_q.bresp;
  assign rvalid = s_q.rvalid;
  assign rdata = s_q.rdata;
  assign rresp = s_q.rresp;

  // Pin drivers: direction zero drives the latch, clock out owns pin four.
  always_comb begin
    gpOut = s_q.latch[5:0];
    gpOe = ~dirEff & ~altMask;
    if (clkOutOn) begin
      gpOut[4] = clkOutSig;
      gpOe[4] = 1'b1;
    end
  end

  // Group pull-ups; the reset pin keeps its pull-up on.
  always_comb begin
    pullUpOn = 6'h00;
    pullUpOn[0] = s_q.pullupEn;
    pullUpOn[1] = s_q.pullupEn;
    pullUpOn[3] = s_q.pullupEn || s_q.rstPinEn;
  end

  // Serial memory lines and the interrupt output.
  assign eeSdaOut = HAS_EEPROM ? s_q.latch[6] : 1'b1;
  assign eeSclOut = HAS_EEPROM ? s_q.latch[7] : 1'b1;
  assign irq = s_q.chgFlag && s_q.chgMask;

  // Helper: no direction write seen since reset.
  logic dirUntouched;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      dirUntouched <= 1'b1;
    end else if (wrDo && wIdx == REG_DIR) begin
      dirUntouched <= 1'b0;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  // Checks tying pins and read data to their causes.
  a_pin3_input: assert property (!gpOe[3])
    else $error("pin three driver enabled");
  a_inputs_reset: assert property (
    dirUntouched && !clkOutOn |-> gpOe == 6'h00)
    else $error("pin driven before any direction write");
  a_port_pins: assert property (
    arvalid && arready && regIndex(araddr) == REG_PORT && !altMask[2]
    |=> rdata[2] == $past(s_q.pinSync[2]))
    else $error("port read did not return pin level");
  a_alt_zero: assert property (
    arvalid && arready && regIndex(araddr) == REG_PORT && s_q.rstPinEn
    |=> rdata[3] == 1'b0)
    else $error("reset pin did not read zero");
  a_dir_fixed: assert property (
    arvalid && arready && regIndex(araddr) == REG_DIR
    |=> rdata[3] && rdata[7:6] == 2'b00)
    else $error("fixed direction bits read wrong");
  a_osc_override: assert property (
    !rcMode |-> gpOe[5:4] == 2'b00 && portView[5:4] == 2'b00)
    else $error("crystal mode left pins four and five to the port");
  a_latch_write: assert property (
    wrDo && wIdx == REG_PORT && s_q.wStrb[0]
    |=> (s_q.latch == $past(s_q.wData[7:0])) ##1 ($stable(s_q.latch)
        || (wrDo && wIdx == REG_PORT)))
    else $error("port write not stored in latch");
  a_dir_driven: assert property (
    wrDo && wIdx == REG_DIR && !s_q.wData[0] && s_q.wStrb[0]
    && !s_q.anaSel[0] |=> gpOe[0] && gpOut[0] == s_q.latch[0])
    else $error("direction zero did not drive latch");
  a_dir45_lock: assert property (
    wrDo && wIdx == REG_DIR && !rcMode |=> $stable(s_q.dir[5:4]))
    else $error("direction five or four changed outside RC mode");
  a_clk_out_pin: assert property (
    clkOutOn |-> gpOe[4] && gpOut[4] == clkOutSig)
    else $error("clock out not on pin four");
  a_chg_enable: assert property (
    $rose(s_q.chgFlag) |-> $past(s_q.portChangeIntEnable))
    else $error("change flag set while disabled");
  a_chg_sticky: assert property (
    s_q.chgFlag && !(wrDo && wIdx == REG_STAT) |=> s_q.chgFlag)
    else $error("change flag dropped without a clear");
  a_pullup_grp: assert property (
    pullUpOn[0] == pullUpOn[1] && pullUpOn[5:4] == 2'b00
    && !pullUpOn[2] && (!s_q.rstPinEn || pullUpOn[3]))
    else $error("pull-up grouping broken");

  // Main scenarios.
  c_port_write: cover property (wrDo && wIdx == REG_PORT);
  c_chg_set: cover property ($rose(s_q.chgFlag));
  c_irq_rise: cover property ($rose(irq));
  c_clear_set: cover property (chgNow && wrDo && wIdx == REG_STAT);

endmodule

// file: verif/spp_pin_model.sv
// Board model that drives the six port pins and the serial memory data line.
module spp_pin_model (
  input wire logic mclk,
  input wire logic [5:0] gpOut,
  input wire logic [5:0] gpOe,
  input wire logic [5:0] pullUpOn,
  input wire logic [5:0] extEn,
  input wire logic [5:0] extVal,
  input wire logic eeSdaOut,
  input wire logic memPull,
  output logic [5:0] gpIn,
  output logic eeSdaIn
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [5:0] floatVal_q = 6'h15;

  // An undriven pin without pull-up wanders every cycle, never a stable value.
  always @(posedge mclk) begin
    floatVal_q <= ~floatVal_q;
  end

  // The board overpowers the port driver; a pull-up beats a floating pin.
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (extEn[i])
        gpIn[i] = extVal[i];
      else if (gpOe[i])
        gpIn[i] = gpOut[i];
      else if (pullUpOn[i])
        gpIn[i] = 1'b1;
      else
        gpIn[i] = floatVal_q[i];
    end
  end

  // The memory pulls the open-drain data line low when it acknowledges.
  assign eeSdaIn = eeSdaOut & ~memPull;
endmodule

// file: verif/spp_port_tb.sv
// Self-checking bench for the six-pin port over its register bus.
module spp_port_tb
  import spp_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 100ps;

  logic mclk = 1'b0;
  logic clock_out_function = 1'b0;
  logic reset_n;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, eeSdaIn;
  logic eeSdaOut, eeSclOut, irq, memPull;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, got;
  logic [1:0] bresp, rresp, rsp;
  logic [5:0] gpIn, gpOut, gpOe, pullUpOn, extEn, extVal;
  int nErrors = 0;
  int compares = 0;

  // One row: a write, then a read with its data and the pin controls.
  typedef struct packed {
    logic [7:0] wa;
    logic [31:0] wd;
    logic [7:0] ra;
    logic [31:0] rd;
    logic [5:0] oe;
    logic [5:0] pu;
  } spp_row_t;

  // The board holds the pins at 2A throughout the table.
  spp_row_t rows [10] = '{
    '{OFF_CFG, 32'h4, OFF_PORT, 32'h2A, 6'h00, 6'h00},
    '{OFF_DIR, 32'h0, OFF_DIR, 32'h08, 6'h37, 6'h00},
    '{OFF_PORT, 32'hFF, OFF_PORT, 32'hEA, 6'h37, 6'h00},
    '{OFF_CFG, 32'h1, OFF_PORT, 32'hCA, 6'h07, 6'h00},
    '{OFF_DIR, 32'h0, OFF_DIR, 32'h38, 6'h07, 6'h00},
    '{OFF_CFG, 32'hC, OFF_PORT, 32'hE2, 6'h37, 6'h08},
    '{OFF_CFG, 32'h24, OFF_PORT, 32'hEA, 6'h37, 6'h0B},
    '{OFF_CFG, 32'h14, OFF_CFG, 32'h14, 6'h37, 6'h00},
    '{OFF_DIR, 32'h10, OFF_DIR, 32'h18, 6'h37, 6'h00},
    '{OFF_CFG, 32'hF04, OFF_PORT, 32'hE8, 6'h20, 6'h00}
  };

  spp_port DUT (
    .mclk(mclk), .reset_n(reset_n), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(4'hF), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .gpIn(gpIn), .gpOut(gpOut), .gpOe(gpOe),
    .pullUpOn(pullUpOn), .clkOutSig(clock_out_function), .eeSdaIn(eeSdaIn),
    .eeSdaOut(eeSdaOut), .eeSclOut(eeSclOut), .irq(irq)
  );

  spp_pin_model board (
    .mclk(mclk), .gpOut(gpOut), .gpOe(gpOe), .pullUpOn(pullUpOn),
    .extEn(extEn), .extVal(extVal), .eeSdaOut(eeSdaOut),
    .memPull(memPull), .gpIn(gpIn), .eeSdaIn(eeSdaIn)
  );

  // Core clock and a slower clock-out waveform for pin four.
  always #2.5 mclk = ~mclk;
  always @(posedge mclk) clock_out_function <= ~clock_out_function;

  // Counts a comparison and reports a mismatch at once.
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      nErrors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Bus write; holds each channel until taken, waits for the response.
  task automatic axWrite(logic [7:0] a, logic [31:0] d);
    logic ah = 1'b0;
    logic wh = 1'b0;
    logic bh = 1'b0;
    @(posedge mclk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    // Waits as long as it takes; only the watchdog ends a hang.
    while (!bh) begin
      @(negedge mclk);
      ah = awvalid & awready;
      wh = wvalid & wready;
      bh = bvalid;
      rsp = bresp;
      @(posedge mclk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    @(negedge mclk);
  endtask

  // Bus read; the data and response are taken on the falling edge before the handshake edge.
  task automatic axRead(logic [7:0] a);
    logic ah = 1'b0;
    logic rh = 1'b0;
    @(posedge mclk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    while (!rh) begin
      @(negedge mclk);
      ah = arvalid & arready;
      rh = rvalid;
      got = rdata;
      rsp = rresp;
      @(posedge mclk);
      if (ah) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    @(negedge mclk);
  endtask

  // Prints the verdict and ends the run.
  task automatic finalReport();
    if (nErrors == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Cuts a hang short.
  initial begin
    repeat (20000) @(posedge mclk);
    nErrors++;
    finalReport();
  end

  // Main sequence: table rows, then hand-written cases.
  initial begin
    reset_n = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, memPull} = 6'h0;
    {awaddr, araddr, wdata} = 48'h0;
    extEn = 6'h3F;
    extVal = 6'h2A;
    repeat (6) @(posedge mclk);
    reset_n <= 1'b1;
    foreach (rows[i]) begin
      axWrite(rows[i].wa, rows[i].wd);
      chk("bresp", {30'h0, RESP_OKAY}, {30'h0, rsp});
      axRead(rows[i].ra);
      chk("rdata", rows[i].rd, got);
      chk("gpOe", {26'h0, rows[i].oe}, {26'h0, gpOe});
      chk("pull", {26'h0, rows[i].pu}, {26'h0, pullUpOn});
    end
    // Latch bits six and seven reach the serial memory lines.
    chk("scl", 32'h1, {31'h0, eeSclOut});
    chk("sdaOut", 32'h1, {31'h0, eeSdaOut});
    chk("pin5", 32'h1, {31'h0, gpOut[5]});
    @(posedge mclk) memPull <= 1'b1;
    // The data line passes two synchroniser stages before a read sees it.
    repeat (2) @(posedge mclk);
    axRead(OFF_PORT);
    chk("sdaIn", 32'hA8, got);
    @(posedge mclk) memPull <= 1'b0;
    // An unmapped place answers with an error and reads zero.
    axWrite(8'h18, 32'hFF);
    chk("bresp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
    axRead(8'h18);
    chk("rresp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
    chk("rdata", 32'h0, got);
    // Change interrupt: pin two is ignored, pin zero raises the flag.
    axWrite(OFF_CFG, 32'h4);
    axWrite(OFF_DIR, 32'h3F);
    axWrite(OFF_MASK, 32'h1);
    axWrite(OFF_INTCTL, 32'h8);
    axRead(OFF_PORT);
    @(posedge mclk) extVal <= 6'h2E;
    repeat (8) @(negedge mclk);
    chk("irqPin2", 32'h0, {31'h0, irq});
    @(posedge mclk) extVal <= 6'h2F;
    for (int k = 0; k < 20 && irq !== 1'b1; k++) @(negedge mclk);
    chk("irqSet", 32'h1, {31'h0, irq});
    axRead(OFF_PORT);
    axWrite(OFF_STAT, 32'h1);
    repeat (4) @(negedge mclk);
    chk("irqClr", 32'h0, {31'h0, irq});
    // With the enable off a change leaves the flag clear.
    axWrite(OFF_INTCTL, 32'h0);
    @(posedge mclk) extVal <= 6'h2D;
    repeat (8) @(negedge mclk);
    axRead(OFF_STAT);
    chk("statOff", 32'h0, got);
    // A masked flag sets status but keeps the interrupt low.
    axWrite(OFF_MASK, 32'h0);
    axWrite(OFF_INTCTL, 32'h8);
    repeat (8) @(negedge mclk);
    axRead(OFF_STAT);
    chk("statMsk", 32'h1, got);
    chk("irqMsk", 32'h0, {31'h0, irq});
    // A second reset restores inputs, analog pins and all directions.
    @(posedge mclk) reset_n <= 1'b0;
    repeat (2) @(negedge mclk);
    chk("oeRst", 32'h0, {26'h0, gpOe});
    chk("irqRst", 32'h0, {31'h0, irq});
    @(posedge mclk) reset_n <= 1'b1;
    axRead(OFF_DIR);
    chk("dirRst", 32'h3F, got);
    axRead(OFF_PORT);
    chk("portRst", 32'h28, got);
    finalReport();
  end
endmodule
